// [lel_trigger.sv]
// limit event trigger line generator with axi4-lite register slave
// Behaviour
// - each of eight lines has min and/or max limits per any of 48 channels
// - line goes high on an over-limit from any channel assigned to it
// - compare filtered results, so filter delay adds to trigger latency
// - latched mode holds line high until reset or new sequence
// - unlatched mode decides line once per scan: low if all ok
// - thirty rate settings up to 10000 Sa/s; 25000 only with few channels
// - arm and trigger sources selected independently from four kinds
// - eight lines presented identically on two parallel ports
`timescale 1ns/1ps
module lel_trigger
   import lel_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   // filtered results and event inputs
   input wire lel_result_type result,
   input wire logic timer_evt,
   input wire logic dio_evt,
   input wire logic trigbus_evt,
   // trigger bus ports
   output logic [NUM_LINES-1:0] trig_port_a,
   output logic [NUM_LINES-1:0] trig_port_b,
   output logic [RATE_W-1:0] rate_sel,
   output logic scan_run,
   output logic irq,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // limit table in flip-flops, indexed by line*48+chan
   lel_limit_type lim [NUM_LINES*NUM_CHAN];
   logic [NUM_LINES-1:0] lines, next_lines;
   logic [NUM_LINES-1:0] viol, next_viol;
   logic [NUM_LINES-1:0] latch_en;
   logic [2:0] sel_line;
   logic [CHAN_W-1:0] sel_chan;
   logic [RATE_W-1:0] rate;
   logic [CHAN_W:0] nchan;
   lel_src_type arm_src, trg_src;
   lel_seq_type seq, next_seq;
   logic [1:0] irq_stat, irq_mask, next_irq_stat;
   logic rate_err;
   // bus state
   logic aw_hold, w_hold, bvalid, rvalid, arready;
   logic [7:0] aw_addr;
   logic [31:0] w_data, rdata;
   logic [1:0] bresp, rresp;
   logic wr_go, rd_go, newseq;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= OFS_NCHAN);
   endfunction

   function automatic logic src_hit(input lel_src_type s, input logic t,
                                    input logic d, input logic b);
      case (s)
         LEL_SRC_IMMEDIATE: src_hit = 1'b1;
         LEL_SRC_TIMER: src_hit = t;
         LEL_SRC_DIO: src_hit = d;
         LEL_SRC_TRIGBUS: src_hit = b;
         default: src_hit = 1'b0;
      endcase
   endfunction

   function automatic int idx(input logic [2:0] l, input logic [CHAN_W-1:0] c);
      idx = int'(l) * NUM_CHAN + int'(c);
   endfunction

   assign wr_go = aw_hold && w_hold && !bvalid;
   assign rd_go = s_axi_arvalid && arready && !rvalid;
   assign newseq = wr_go && aw_addr == OFS_CTRL && w_data[CTRL_NEWSEQ_BIT];

   // bus handshake: address and data taken independently
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         bvalid <= 1'b0;
         bresp <= 2'h0;
         rvalid <= 1'b0;
         rresp <= 2'h0;
         rdata <= 32'h0000_0000;
         arready <= 1'b0;
      end else if (clk_en) begin
         arready <= !rvalid && !arready;
         if (s_axi_awvalid && !aw_hold) begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_hold) begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
         end
         if (wr_go) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            bvalid <= 1'b1;
            bresp <= mapped(aw_addr) ? 2'h0 : 2'h2;
         end else if (bvalid && s_axi_bready) begin
            bvalid <= 1'b0;
         end
         if (rd_go) begin
            rvalid <= 1'b1;
            arready <= 1'b0;
            rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
            case (s_axi_araddr)
               OFS_CTRL: rdata <= {24'h0, latch_en};
               OFS_STATUS: rdata <= {19'h0, seq == LEL_SCAN, rate_err,
                                     3'h0, lines};
               OFS_IRQ_STAT: rdata <= {30'h0, irq_stat};
               OFS_IRQ_MASK: rdata <= {30'h0, irq_mask};
               OFS_SEL: rdata <= {18'h0, sel_chan, 5'h0, sel_line};
               OFS_LIMIT: rdata <= {8'h0, lim[idx(sel_line, sel_chan)].max_lim};
               OFS_ENMASK: rdata <= {30'h0, lim[idx(sel_line, sel_chan)].max_en,
                                     lim[idx(sel_line, sel_chan)].min_en};
               OFS_SRC: rdata <= {26'h0, trg_src, 2'h0, arm_src};
               OFS_RATE: rdata <= {27'h0, rate};
               OFS_NCHAN: rdata <= {25'h0, nchan};
               default: rdata <= 32'h0000_0000;
            endcase
         end else if (rvalid && s_axi_rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // configuration registers; wstrb assumed full-word for simplicity
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         latch_en <= CTRL_RESET[NUM_LINES-1:0];
         irq_mask <= 2'h0;
         sel_line <= 3'h0;
         sel_chan <= 6'h00;
         arm_src <= LEL_SRC_IMMEDIATE;
         trg_src <= LEL_SRC_IMMEDIATE;
         rate <= RATE_RESET;
         nchan <= NCHAN_RESET;
         rate_err <= 1'b0;
      end else if (clk_en && wr_go) begin
         case (aw_addr)
            OFS_CTRL: latch_en <= w_data[CTRL_LATCH_LO +: NUM_LINES];
            OFS_IRQ_MASK: irq_mask <= w_data[1:0];
            OFS_SEL: begin
               sel_line <= w_data[SEL_LINE_LO +: 3];
               sel_chan <= (w_data[SEL_CHAN_LO +: CHAN_W] < CHAN_W'(NUM_CHAN))
                  ? w_data[SEL_CHAN_LO +: CHAN_W] : sel_chan;
            end
            OFS_SRC: begin
               arm_src <= lel_src_type'(w_data[SRC_ARM_LO +: 2]);
               trg_src <= lel_src_type'(w_data[SRC_TRG_LO +: 2]);
            end
            OFS_RATE: begin
               if (w_data[RATE_W-1:0] < RATE_W'(NUM_RATES)) begin
                  rate <= w_data[RATE_W-1:0];
                  rate_err <= 1'b0;
               end else if (w_data[RATE_W-1:0] == RATE_FAST &&
                            nchan <= 7'(FAST_CHAN_MAX)) begin
                  rate <= RATE_FAST;
                  rate_err <= 1'b0;
               end else begin
                  rate_err <= 1'b1;
               end
            end
            OFS_NCHAN: begin
               if (w_data[CHAN_W:0] <= 7'(NUM_CHAN))
                  nchan <= w_data[CHAN_W:0];
               if (rate == RATE_FAST && w_data[CHAN_W:0] > 7'(FAST_CHAN_MAX))
                  rate <= RATE_RESET;
            end
            default: ;
         endcase
      end
   end

   // limit table: max written with value word, min with upper flag
   genvar gi;
   generate
      for (gi = 0; gi < NUM_LINES*NUM_CHAN; gi++) begin : g_lim
         always_ff @(posedge sys_clk) begin
            if (reset) begin
               lim[gi] <= '0;
            end else if (clk_en && wr_go && idx(sel_line, sel_chan) == gi) begin
               if (aw_addr == OFS_LIMIT && !w_data[31])
                  lim[gi].max_lim <= w_data[DATA_W-1:0];
               if (aw_addr == OFS_LIMIT && w_data[31])
                  lim[gi].min_lim <= w_data[DATA_W-1:0];
               if (aw_addr == OFS_ENMASK) begin
                  lim[gi].min_en <= w_data[EN_MIN_BIT];
                  lim[gi].max_en <= w_data[EN_MAX_BIT];
               end
            end
         end
      end
   endgenerate

   // sequence and line evaluation
   always_comb begin
      lel_limit_type e;
      e = '0;
      next_seq = seq;
      next_viol = viol;
      next_lines = lines;
      next_irq_stat = irq_stat;
      case (seq)
         LEL_IDLE: if (newseq) next_seq = LEL_WAIT_ARM;
         LEL_WAIT_ARM:
            if (src_hit(arm_src, timer_evt, dio_evt, trigbus_evt))
               next_seq = LEL_WAIT_TRIG;
         LEL_WAIT_TRIG:
            if (src_hit(trg_src, timer_evt, dio_evt, trigbus_evt))
               next_seq = LEL_SCAN;
         LEL_SCAN: ;
         default: next_seq = LEL_IDLE;
      endcase
      // results arrive after the filters, so latency follows them
      if (seq == LEL_SCAN && result.valid) begin
         for (int l = 0; l < NUM_LINES; l++) begin
            // out-of-range channel numbers compare against nothing
            if (result.chan < CHAN_W'(NUM_CHAN))
               e = lim[l*NUM_CHAN + int'(result.chan)];
            else
               e = '0;
            if ((e.min_en && result.value < e.min_lim) ||
                (e.max_en && result.value > e.max_lim)) begin
               next_viol[l] = 1'b1;
               if (latch_en[l])
                  next_lines[l] = 1'b1;
            end
         end
         if (result.last) begin
            for (int l = 0; l < NUM_LINES; l++) begin
               if (!latch_en[l])
                  next_lines[l] = next_viol[l];
            end
            next_viol = '0;
            next_irq_stat[1] = 1'b1;
         end
      end
      if ((next_lines & ~lines) != '0)
         next_irq_stat[0] = 1'b1;
      // new sequence clears latched lines
      if (newseq) begin
         next_lines = '0;
         next_viol = '0;
         next_seq = LEL_WAIT_ARM;
      end
      // write-one-to-clear, a fresh event wins
      if (wr_go && aw_addr == OFS_IRQ_STAT)
         next_irq_stat = next_irq_stat & ~(w_data[1:0] & ~{
            seq == LEL_SCAN && result.valid && result.last,
            (next_lines & ~lines) != '0});
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         seq <= LEL_IDLE;
         viol <= '0;
         lines <= '0;
         irq_stat <= 2'h0;
      end else if (clk_en) begin
         seq <= next_seq;
         viol <= next_viol;
         lines <= next_lines;
         irq_stat <= next_irq_stat;
      end
   end

   // outputs registered; both ports carry identical lines
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         trig_port_a <= '0;
         trig_port_b <= '0;
         rate_sel <= RATE_RESET;
         scan_run <= 1'b0;
         irq <= 1'b0;
      end else if (clk_en) begin
         trig_port_a <= next_lines;
         trig_port_b <= next_lines;
         rate_sel <= rate;
         scan_run <= next_seq == LEL_SCAN;
         irq <= (next_irq_stat & irq_mask) != 2'h0;
      end
   end

   assign s_axi_awready = !aw_hold;
   assign s_axi_wready = !w_hold;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_arready = arready;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rdata = rdata;
   assign s_axi_rresp = rresp;
endmodule

// [lel_pkg.sv]
// package for the limit event trigger line block
package lel_pkg;
   localparam int NUM_LINES = 8;
   localparam int NUM_CHAN = 48;
   localparam int CHAN_W = 6;
   localparam int DATA_W = 24;
   localparam int NUM_RATES = 30;
   localparam int RATE_W = 5;
   localparam logic [RATE_W-1:0] RATE_FAST = 5'h1e;
   localparam int FAST_CHAN_MAX = 16;
   localparam int FILT_LATENCY_MS = 14;
   localparam int CLK_HZ = 20000000;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
   localparam logic [7:0] OFS_SEL = 8'h10;
   localparam logic [7:0] OFS_LIMIT = 8'h14;
   localparam logic [7:0] OFS_ENMASK = 8'h18;
   localparam logic [7:0] OFS_SRC = 8'h1c;
   localparam logic [7:0] OFS_RATE = 8'h20;
   localparam logic [7:0] OFS_NCHAN = 8'h24;

   // control fields
   localparam int CTRL_LATCH_LO = 0;
   localparam int CTRL_NEWSEQ_BIT = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // select register fields: line 2:0, channel 13:8
   localparam int SEL_LINE_LO = 0;
   localparam int SEL_CHAN_LO = 8;
   // enable register: bit0 min enable, bit1 max enable
   localparam int EN_MIN_BIT = 0;
   localparam int EN_MAX_BIT = 1;
   // source register: arm 1:0, trigger 5:4
   localparam int SRC_ARM_LO = 0;
   localparam int SRC_TRG_LO = 4;
   localparam logic [RATE_W-1:0] RATE_RESET = 5'h00;
   localparam logic [CHAN_W:0] NCHAN_RESET = 7'h30;

   typedef enum logic [1:0] {
      LEL_SRC_IMMEDIATE,
      LEL_SRC_TIMER,
      LEL_SRC_DIO,
      LEL_SRC_TRIGBUS
   } lel_src_type;

   typedef enum {LEL_IDLE, LEL_WAIT_ARM, LEL_WAIT_TRIG, LEL_SCAN} lel_seq_type;

   typedef struct packed {
      logic valid;
      logic last;
      logic [CHAN_W-1:0] chan;
      logic signed [DATA_W-1:0] value;
   } lel_result_type;

   typedef struct packed {
      logic signed [DATA_W-1:0] min_lim;
      logic signed [DATA_W-1:0] max_lim;
      logic min_en;
      logic max_en;
   } lel_limit_type;
endpackage

// [lel_trigger_sva.sv]
// assertion checker for the trigger line block
`timescale 1ns/1ps
module lel_trigger_sva
   import lel_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // results and lines
   input wire lel_result_type result,
   input wire logic [NUM_LINES-1:0] trig_port_a,
   input wire logic [NUM_LINES-1:0] trig_port_b,
   input wire logic [RATE_W-1:0] rate_sel,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   property p_ports_same;
      trig_port_a == trig_port_b;
   endproperty
   a_ports_same: assert property (p_ports_same)
      else $error("trigger ports differ");
   // a line only rises on the cycle after a compared result
   property p_rise_cause;
      |(trig_port_a & ~$past(trig_port_a)) |-> $past(result.valid);
   endproperty
   a_rise_cause: assert property (p_rise_cause)
      else $error("line rose without a result");
   property p_rate_ok;
      rate_sel <= RATE_FAST;
   endproperty
   a_rate_ok: assert property (p_rate_ok)
      else $error("rate code out of range");
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_bhold: assert property (p_bhold)
      else $error("write response dropped early");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold)
      else $error("read data not held");
   property p_ranswer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_ranswer: assert property (p_ranswer)
      else $error("read answer late");
   property p_banswer;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_banswer: assert property (p_banswer)
      else $error("write answer late");
   property p_resp;
      s_axi_rvalid |-> s_axi_rresp inside {2'b00, 2'b10};
   endproperty
   a_resp: assert property (p_resp)
      else $error("bad read response code");
endmodule
bind lel_trigger lel_trigger_sva u_sva (.*);

// [lel_bus_peer.sv]
// trigger bus peer model: listens on both ports, fires bus events
`timescale 1ns/1ps
module lel_bus_peer
   import lel_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // both trigger bus ports
   input wire logic [NUM_LINES-1:0] port_a,
   input wire logic [NUM_LINES-1:0] port_b,
   // event request and bus event
   input wire logic fire,
   output logic bus_evt,
   output int diffs
);
   initial diffs = 0;
   initial bus_evt = 1'b0;
   // a peer on either port must see the same levels
   always @(posedge sys_clk) begin
      if (port_a !== port_b) diffs <= diffs + 1;
      bus_evt <= fire;
   end
endmodule

// [test_lel_trigger.sv]
// self-checking bench for the trigger line block
`timescale 1ns/1ps
module test_lel_trigger
   import lel_pkg::*;
   ;
   logic sys_clk = 0, reset = 1, clk_en = 1, tev = 0, dev = 0, fire = 0;
   lel_result_type result = '0;
   logic [NUM_LINES-1:0] pa, pb;
   logic [RATE_W-1:0] rate_sel;
   logic scan_run, irq, bev, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
   logic awr, wrd, bv, arr, rv;
   logic [7:0] aw = '0, ar = '0;
   logic [31:0] wd = '0, rdat, v;
   logic [1:0] br, rr, r;
   int n_errors = 0, compares = 0, diffs;
   lel_trigger u_dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
      .result(result), .timer_evt(tev), .dio_evt(dev), .trigbus_evt(bev),
      .trig_port_a(pa), .trig_port_b(pb), .rate_sel(rate_sel),
      .scan_run(scan_run), .irq(irq), .s_axi_awaddr(aw),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
      .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rre));
   lel_bus_peer u_peer (.sys_clk(sys_clk), .port_a(pa), .port_b(pb),
      .fire(fire), .bus_evt(bev), .diffs(diffs));
   initial forever #25 sys_clk = ~sys_clk;
   task close_out;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task tick(inout int k);
      k++;
      if (k > 60) begin
         n_errors++;
         close_out;
      end
   endtask
   // ready is sampled mid-cycle; it only moves at rising edges
   task wr(input logic [7:0] a, input logic [31:0] d);
      int k;
      logic ah, wh, bh;
      k = 0;
      bh = 0;
      @(posedge sys_clk);
      aw <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      bre <= 1;
      while (!bh) begin
         @(negedge sys_clk);
         ah = awv && awr;
         wh = wv && wrd;
         bh = bv;
         @(posedge sys_clk);
         if (ah) awv <= 0;
         if (wh) wv <= 0;
         tick(k);
      end
      bre <= 0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
      int k;
      logic hs, got;
      k = 0;
      got = 0;
      @(posedge sys_clk);
      ar <= a;
      arv <= 1;
      rre <= 1;
      while (!got) begin
         @(negedge sys_clk);
         hs = arv && arr;
         got = rv;
         d = rdat;
         s = rr;
         @(posedge sys_clk);
         if (hs) arv <= 0;
         tick(k);
      end
      rre <= 0;
   endtask
   task cfg(input logic [2:0] ln, input logic [5:0] ch, input int mx,
            input int mn, input logic [1:0] en);
      wr(OFS_SEL, {18'h0, ch, 5'h0, ln});
      wr(OFS_LIMIT, {8'h00, mx[DATA_W-1:0]});
      wr(OFS_LIMIT, {8'h80, mn[DATA_W-1:0]});
      wr(OFS_ENMASK, {30'h0, en});
   endtask
   // one result, then the lines two settled cycles later
   task send(input logic [5:0] c, input int val, input logic l,
             input logic [7:0] exp);
      @(posedge sys_clk);
      result <= '{1'b1, l, c, val[DATA_W-1:0]};
      @(posedge sys_clk);
      result.valid <= 1'b0;
      repeat (2) @(negedge sys_clk);
      check({24'h0, pa}, {24'h0, exp});
   endtask
   task wait_scan;
      int k;
      k = 0;
      while (scan_run !== 1'b1) begin
         @(negedge sys_clk);
         tick(k);
      end
      check({31'h0, scan_run}, 32'h1);
   endtask
   task pulse(input int k);
      @(posedge sys_clk);
      {fire, dev, tev} <= 3'(1 << (k - 1));
      @(posedge sys_clk);
      {fire, dev, tev} <= 3'h0;
      repeat (3) @(posedge sys_clk);
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      reset <= 0;
      rd(OFS_NCHAN, v, r);
      check(v, 32'h30);
      rd(8'h28, v, r);
      check({30'h0, r}, 32'h2);
      cfg(3'h0, 6'h05, 100, -100, 2'h3);
      cfg(3'h2, 6'h2f, 10, 0, 2'h2);
      rd(OFS_LIMIT, v, r);
      check(v, 32'ha);
      rd(OFS_ENMASK, v, r);
      check(v, 32'h2);
      wr(OFS_SEL, 32'h3f00);
      rd(OFS_SEL, v, r);
      check(v, 32'h2f00);
      wr(OFS_SRC, 32'h0);
      wr(OFS_CTRL, 32'h101);
      wait_scan;
      send(6'h05, 50, 1, 8'h00);
      send(6'h07, 5000, 1, 8'h00);
      send(6'h05, 200, 0, 8'h01);
      send(6'h05, 0, 1, 8'h01);
      send(6'h2f, -1000, 1, 8'h01);
      send(6'h2f, 11, 0, 8'h01);
      send(6'h2f, 11, 1, 8'h05);
      send(6'h2f, 10, 1, 8'h01);
      rd(OFS_STATUS, v, r);
      check(v & 32'hff, 32'h01);
      rd(OFS_IRQ_STAT, v, r);
      check(v & 32'h1, 32'h1);
      wr(OFS_IRQ_STAT, 32'h1);
      rd(OFS_IRQ_STAT, v, r);
      check(v & 32'h1, 32'h0);
      wr(OFS_CTRL, 32'h100);
      repeat (2) @(negedge sys_clk);
      check({24'h0, pa}, 32'h0);
      send(6'h05, -150, 1, 8'h01);
      send(6'h05, -100, 1, 8'h00);
      for (int k = 1; k < 4; k++) begin
         wr(OFS_SRC, 32'(k * 17));
         wr(OFS_CTRL, 32'h100);
         repeat (3) @(negedge sys_clk);
         check({31'h0, scan_run}, 32'h0);
         pulse(k);
         pulse(k);
         wait_scan;
      end
      for (int c = 0; c < 31; c++) begin
         wr(OFS_RATE, 32'(c));
         @(negedge sys_clk);
         check({27'h0, rate_sel}, (c < 30) ? c : 29);
      end
      rd(OFS_STATUS, v, r);
      check((v >> 11) & 32'h1, 32'h1);
      wr(OFS_NCHAN, 32'd16);
      wr(OFS_RATE, 32'd30);
      @(negedge sys_clk);
      check({27'h0, rate_sel}, 32'd30);
      check({31'h0, irq}, 32'h0);
      wr(OFS_IRQ_MASK, 32'h2);
      @(negedge sys_clk);
      check({31'h0, irq}, 32'h1);
      wr(OFS_IRQ_STAT, 32'h2);
      @(negedge sys_clk);
      check({31'h0, irq}, 32'h0);
      wr(OFS_CTRL, 32'h1);
      @(posedge sys_clk);
      clk_en <= 1'b0;
      send(6'h05, 500, 0, 8'h00);
      @(posedge sys_clk);
      clk_en <= 1'b1;
      send(6'h05, 500, 0, 8'h01);
      send(6'h05, 0, 1, 8'h01);
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      @(negedge sys_clk);
      check({24'h0, pa}, 32'h0);
      check({31'h0, irq}, 32'h0);
      rd(OFS_NCHAN, v, r);
      check(v, 32'h30);
      check(32'(diffs), 32'h0);
      close_out;
   end
   initial begin
      repeat (60000) @(posedge sys_clk);
      n_errors++;
      close_out;
   end
endmodule
